// >>> logic/wsr_pkg.sv
package wsr_pkg;

  // Register offsets on the core register bus
  localparam logic [7:0] OFS_COUNT_HIGH = 8'hC2;
  localparam logic [7:0] OFS_COUNT_LOW = 8'hC3;
  localparam logic [7:0] OFS_TIMER_CONTROL_HIGH = 8'hC1;
  localparam logic [7:0] OFS_FLAGS = 8'hFC;

  // Timer control high: timeout select field and write-once upper bits
  localparam int SEL_LSB = 4;
  localparam int SEL_MSB = 6;
  localparam int ONCE_LSB = 3;
  localparam logic [7:0] CTL_HIGH_RESET = 8'h70;
  localparam logic [2:0] SEL_DISABLED = 3'h0;

  // Flags register bit positions
  localparam int FLAG_DOG = 1;
  localparam int FLAG_RECOVERY = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Core decode of the stop instruction
  localparam logic [7:0] STOP_OPCODE = 8'h6F;

  // Restart vector after any reset source
  localparam logic [15:0] RESTART_VECTOR = 16'h0020;

  // Watchdog timing, in crystal periods
  localparam int PRESCALE = 64;
  localparam logic [5:0] PRESCALE_LAST = 6'(PRESCALE - 1);
  localparam int TIMEOUT_MIN_PERIODS = 65536;
  localparam int TICKS_MIN = TIMEOUT_MIN_PERIODS / PRESCALE;
  localparam logic [15:0] COUNT_RESET = 16'hFFFF;

  // Synchronized reset pin release to first fetch, in crystal periods
  localparam logic [3:0] START_DELAY = 4'hA;

  // Recovery pulse: least width in ns, clock period in ns
  localparam int CLK_PERIOD_NS = 20;
  localparam int RECOVERY_PULSE_NS = 12;
  localparam int REC_CYC_RAW =
    (RECOVERY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] RECOVERY_CYCLES =
    2'((REC_CYC_RAW < 1) ? 1 : REC_CYC_RAW);

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_STOP,
    MODE_WAKE
  } wsr_mode_e;

endpackage

// >>> logic/wsr_watchdog_stop_recovery.sv
// Overview of operation
// - Retriggerable 16-bit down counter resets at terminal
// - Counter steps once per 64 crystal cycles
// - Timeout restarts at 0020H, sets dog flag
// - Reset enables watchdog, select defaults all ones
// - Retrigger reloads both count bytes from select
// - No disable except first instruction; stop halts
// - Upper five control bits writable first instruction
// - Timeout beside retrigger still takes effect
// - Pin reset clears only dog, recovery flags
// - Timeout sets dog flag; stop sets recovery
// - Reading flags never clears; software clears
// - Select 000 off; others double from 65536
// - Stop opcode alone enters stop, oscillator off
// - Stop ends by pin or recovery; restart 0020H
// - Recovery pin low, configured input, wakes device
// - Resume only after recovery pin returns high
// - Recovery wake keeps control registers unchanged
// - Filtered clock feeds divide by two, four, eight
// - Execution starts twelve cycles after pin release
// - Only pin reset restores control defaults
module wsr_watchdog_stop_recovery (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Pins
  input wire logic resetPinN,
  input wire logic recoveryPin,
  // Port direction state of the recovery pin
  input wire logic recoveryPinIsInput,
  // Core instruction events
  input wire logic instrDone,
  input wire logic [7:0] instrOpcode,
  input wire logic dogRetrigger,
  // Register bus
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // Core control
  output logic coreHold,
  output logic restartPulse,
  output logic [15:0] restartAddr,
  output logic oscEnable,
  output logic stopMode,
  // Derived clocks
  output logic clkDiv2,
  output logic clkDiv4,
  output logic clkDiv8,
  // Reset source flags
  output logic dogFlag,
  output logic recoveryFlag
);

  typedef struct packed {
    logic rstSync1;
    logic rstSync2;
    logic recSync1;
    logic recSync2;
    logic [3:0] startCnt;
    logic coreHold;
    logic restartPulse;
    logic [15:0] restartAddr;
    logic firstWin;
    logic [7:0] ctlHigh;
    logic [15:0] count;
    logic [5:0] prescale;
    logic [7:0] flags;
    wsr_pkg::wsr_mode_e mode;
    logic stopMode;
    logic [1:0] recLowCnt;
    logic oscEnable;
    logic [2:0] div;
    logic [7:0] rdData;
  } wsr_state_s;

  localparam wsr_state_s STATE_RESET = '{
    rstSync1: 1'b0,
    rstSync2: 1'b0,
    recSync1: 1'b1,
    recSync2: 1'b1,
    startCnt: wsr_pkg::START_DELAY,
    coreHold: 1'b1,
    restartPulse: 1'b0,
    restartAddr: wsr_pkg::RESTART_VECTOR,
    firstWin: 1'b1,
    ctlHigh: wsr_pkg::CTL_HIGH_RESET,
    count: wsr_pkg::COUNT_RESET,
    prescale: 6'h00,
    flags: wsr_pkg::FLAGS_RESET,
    mode: wsr_pkg::MODE_RUN,
    stopMode: 1'b0,
    recLowCnt: 2'h0,
    oscEnable: 1'b1,
    div: 3'h0,
    rdData: 8'h00
  };

  wsr_state_s s;
  wsr_state_s next_s;

  logic [2:0] sel;
  logic dogEnabled;
  logic dogRunning;
  logic tick;
  logic timeout;
  logic [16:0] span;
  logic [16:0] spanLess;
  logic [15:0] reloadValue;
  logic stopExec;

  // Timeout select decode: each nonzero code doubles the period
  always_comb begin
    sel = s.ctlHigh[wsr_pkg::SEL_MSB:wsr_pkg::SEL_LSB];
    dogEnabled = sel != wsr_pkg::SEL_DISABLED;
    span = 17'(wsr_pkg::TICKS_MIN) << (sel - 3'h1);
    spanLess = span - 17'h00001;
    reloadValue = spanLess[15:0];
    // Stop mode and the held core both freeze the watchdog
    dogRunning = dogEnabled && (s.mode == wsr_pkg::MODE_RUN)
      && !s.coreHold;
    tick = dogRunning && (s.prescale == wsr_pkg::PRESCALE_LAST);
    timeout = tick && (s.count == 16'h0000);
    stopExec = instrDone && (instrOpcode == wsr_pkg::STOP_OPCODE)
      && (s.mode == wsr_pkg::MODE_RUN) && !s.coreHold;
  end

  always_comb begin
    next_s = s;
    next_s.rstSync1 = resetPinN;
    next_s.rstSync2 = s.rstSync1;
    next_s.recSync1 = recoveryPin;
    next_s.recSync2 = s.recSync1;
    next_s.restartPulse = 1'b0;
    next_s.rdData = 8'h00;

    // Divider chain runs only while the oscillator is on
    if (s.oscEnable) begin
      next_s.div = s.div + 3'h1;
    end

    // Register reads have no side effect
    if (regRd) begin
      case (regAddr)
        wsr_pkg::OFS_COUNT_HIGH: next_s.rdData = s.count[15:8];
        wsr_pkg::OFS_COUNT_LOW: next_s.rdData = s.count[7:0];
        wsr_pkg::OFS_TIMER_CONTROL_HIGH: next_s.rdData = s.ctlHigh;
        wsr_pkg::OFS_FLAGS: next_s.rdData = s.flags;
        default: next_s.rdData = 8'h00;
      endcase
    end

    // Prescaler
    if (dogRunning) begin
      next_s.prescale = s.prescale + 6'h01;
    end else begin
      next_s.prescale = 6'h00;
    end

    // Counter decrement; software writes take priority
    if (tick && !timeout) begin
      next_s.count = s.count - 16'h0001;
    end
    if (regWr && (regAddr == wsr_pkg::OFS_COUNT_HIGH)) begin
      next_s.count[15:8] = regWrData;
    end
    if (regWr && (regAddr == wsr_pkg::OFS_COUNT_LOW)) begin
      next_s.count[7:0] = regWrData;
    end
    if (dogRetrigger && dogEnabled && !s.coreHold) begin
      next_s.count = reloadValue;
      next_s.prescale = 6'h00;
    end

    // Control: low bits always, upper bits only in first instruction
    if (regWr && (regAddr == wsr_pkg::OFS_TIMER_CONTROL_HIGH)) begin
      next_s.ctlHigh[wsr_pkg::ONCE_LSB-1:0] =
        regWrData[wsr_pkg::ONCE_LSB-1:0];
      if (s.firstWin) begin
        next_s.ctlHigh[7:wsr_pkg::ONCE_LSB] =
          regWrData[7:wsr_pkg::ONCE_LSB];
      end
    end
    if (instrDone && !s.coreHold) begin
      next_s.firstWin = 1'b0;
    end

    // Flags: plain bits store, source flags clear on written zero
    if (regWr && (regAddr == wsr_pkg::OFS_FLAGS)) begin
      next_s.flags = regWrData;
      next_s.flags[wsr_pkg::FLAG_DOG] =
        s.flags[wsr_pkg::FLAG_DOG] & regWrData[wsr_pkg::FLAG_DOG];
      next_s.flags[wsr_pkg::FLAG_RECOVERY] = s.flags[wsr_pkg::FLAG_RECOVERY]
        & regWrData[wsr_pkg::FLAG_RECOVERY];
    end

    // Timeout wins over a retrigger in the same cycle
    if (timeout) begin
      next_s.count = reloadValue;
      next_s.prescale = 6'h00;
      next_s.flags[wsr_pkg::FLAG_DOG] = 1'b1;
      next_s.restartPulse = 1'b1;
      next_s.restartAddr = wsr_pkg::RESTART_VECTOR;
    end

    // Stop mode sequencing
    unique case (s.mode)
      wsr_pkg::MODE_RUN: begin
        next_s.recLowCnt = 2'h0;
        if (stopExec) begin
          next_s.mode = wsr_pkg::MODE_STOP;
          next_s.oscEnable = 1'b0;
          next_s.flags[wsr_pkg::FLAG_RECOVERY] = 1'b1;
        end
      end
      wsr_pkg::MODE_STOP: begin
        if (!s.recSync2 && recoveryPinIsInput) begin
          if (s.recLowCnt == wsr_pkg::RECOVERY_CYCLES - 2'h1) begin
            next_s.mode = wsr_pkg::MODE_WAKE;
            next_s.oscEnable = 1'b1;
          end else begin
            next_s.recLowCnt = s.recLowCnt + 2'h1;
          end
        end else begin
          next_s.recLowCnt = 2'h0;
        end
      end
      wsr_pkg::MODE_WAKE: begin
        if (s.recSync2) begin
          // Control registers are left as they were
          next_s.mode = wsr_pkg::MODE_RUN;
          next_s.restartPulse = 1'b1;
          next_s.restartAddr = wsr_pkg::RESTART_VECTOR;
        end
      end
    endcase

    // Reset pin: hold the core, restore defaults, then count out
    if (!s.rstSync2) begin
      next_s.coreHold = 1'b1;
      next_s.startCnt = wsr_pkg::START_DELAY;
      next_s.flags[wsr_pkg::FLAG_DOG] = 1'b0;
      next_s.flags[wsr_pkg::FLAG_RECOVERY] = 1'b0;
      next_s.ctlHigh = wsr_pkg::CTL_HIGH_RESET;
      next_s.count = wsr_pkg::COUNT_RESET;
      next_s.prescale = 6'h00;
      next_s.firstWin = 1'b1;
      next_s.mode = wsr_pkg::MODE_RUN;
      next_s.recLowCnt = 2'h0;
      next_s.oscEnable = 1'b1;
      next_s.restartPulse = 1'b0;
    end else if (s.coreHold) begin
      if (s.startCnt == 4'h1) begin
        next_s.coreHold = 1'b0;
        next_s.restartPulse = 1'b1;
        next_s.restartAddr = wsr_pkg::RESTART_VECTOR;
      end else begin
        next_s.startCnt = s.startCnt - 4'h1;
      end
    end
    next_s.stopMode = (next_s.mode != wsr_pkg::MODE_RUN);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign regRdData = s.rdData;
  assign coreHold = s.coreHold;
  assign restartPulse = s.restartPulse;
  assign restartAddr = s.restartAddr;
  assign oscEnable = s.oscEnable;
  assign stopMode = s.stopMode;
  assign clkDiv2 = s.div[0];
  assign clkDiv4 = s.div[1];
  assign clkDiv8 = s.div[2];
  assign dogFlag = s.flags[wsr_pkg::FLAG_DOG];
  assign recoveryFlag = s.flags[wsr_pkg::FLAG_RECOVERY];

endmodule // wsr_watchdog_stop_recovery

// >>> verif/wsr_watchdog_stop_recovery_assertions.sv
module wsr_watchdog_stop_recovery_assertions (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Pins and core events
  input wire logic resetPinN,
  input wire logic recoveryPin,
  input wire logic instrDone,
  input wire logic [7:0] instrOpcode,
  input wire logic [7:0] regAddr,
  input wire logic regRd,
  // Design outputs
  input wire logic [7:0] regRdData,
  input wire logic coreHold,
  input wire logic restartPulse,
  input wire logic [15:0] restartAddr,
  input wire logic oscEnable,
  input wire logic stopMode,
  input wire logic clkDiv2,
  input wire logic clkDiv4,
  input wire logic dogFlag,
  input wire logic recoveryFlag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_vec;
    restartPulse |-> restartAddr == 16'h0020;
  endproperty
  a_vec: assert property (p_vec) else $error("bad restart address");
  property p_stop;
    instrDone && instrOpcode == 8'h6F && !stopMode && !coreHold
      |=> stopMode && !oscEnable && recoveryFlag;
  endproperty
  a_stop: assert property (p_stop) else $error("stop entry wrong");
  property p_keep;
    dogFlag && regRd && resetPinN && $past(resetPinN) && $past(resetPinN, 2)
      |=> dogFlag;
  endproperty
  a_keep: assert property (p_keep) else $error("read cleared flag");
  property p_hold;
    !recoveryPin [*4] ##0 stopMode |-> !restartPulse;
  endproperty
  a_hold: assert property (p_hold) else $error("woke with pin low");
  property p_start;
    $rose(resetPinN) |-> !restartPulse [*8] ##5 restartPulse;
  endproperty
  a_start: assert property (p_start) else $error("start delay wrong");
  property p_pin;
    !resetPinN [*5] |-> coreHold && !stopMode && !dogFlag && !recoveryFlag;
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset state wrong");
  property p_div;
    $rose(clkDiv4) |-> $fell(clkDiv2);
  endproperty
  a_div: assert property (p_div) else $error("divider chain wrong");
  property p_rdf;
    regRd && regAddr == 8'hFC
      |=> regRdData[1:0] == $past({dogFlag, recoveryFlag});
  endproperty
  a_rdf: assert property (p_rdf) else $error("flag readback wrong");
  c_stop: cover property (stopMode && !oscEnable);
  c_dog: cover property ($rose(dogFlag));
  c_rs: cover property (restartPulse);
endmodule // wsr_watchdog_stop_recovery_assertions

bind wsr_watchdog_stop_recovery wsr_watchdog_stop_recovery_assertions
  u_wsr_watchdog_stop_recovery_assertions (.mclk, .rst_n, .resetPinN,
  .recoveryPin, .instrDone, .instrOpcode, .regAddr, .regRd, .regRdData,
  .coreHold, .restartPulse, .restartAddr, .oscEnable, .stopMode, .clkDiv2,
  .clkDiv4, .dogFlag, .recoveryFlag);

// >>> verif/wsr_pin_model.sv
module wsr_pin_model (
  // Clock
  input wire logic mclk,
  // Pins
  output logic resetPinN,
  output logic recoveryPin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    resetPinN = 1'b0;
    recoveryPin = 1'b1;
  end
  task automatic pinReset(input int cyc);
    resetPinN <= 1'b0;
    repeat (cyc) @(posedge mclk);
    resetPinN <= 1'b1;
  endtask
  // Low time covers the least width and oscillator start-up
  task automatic wake(input int cyc);
    @(posedge mclk);
    recoveryPin <= 1'b0;
    repeat (cyc) @(posedge mclk);
    recoveryPin <= 1'b1;
  endtask
endmodule // wsr_pin_model

// >>> verif/wsr_watchdog_stop_recovery_tb_top.sv
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module wsr_watchdog_stop_recovery_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic recoveryPinIsInput = 1'b1;
  logic instrDone = 1'b0;
  logic [7:0] instrOpcode = 8'h00;
  logic dogRetrigger = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic resetPinN, recoveryPin, coreHold, restartPulse, oscEnable, stopMode;
  logic dogFlag, recoveryFlag;
  logic [7:0] regRdData;
  logic [15:0] restartAddr;
  logic [15:0] rnd = 16'd15783;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  always #10 mclk = ~mclk;
  wsr_pin_model u_wsr_pin_model (.mclk, .resetPinN, .recoveryPin);
  wsr_watchdog_stop_recovery u_wsr_watchdog_stop_recovery (.mclk, .rst_n,
    .resetPinN, .recoveryPin, .recoveryPinIsInput, .instrDone, .instrOpcode,
    .dogRetrigger, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .coreHold, .restartPulse, .restartAddr, .oscEnable, .stopMode,
    .clkDiv2(), .clkDiv4(), .clkDiv8(), .dogFlag, .recoveryFlag);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] expHigh(input int sel);
    return 8'(((1024 << (sel - 1)) - 1) >> 8);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 `CHK(regRdData, e)
  endtask
  task automatic issue(input logic [7:0] op);
    @(posedge mclk);
    instrDone <= 1'b1;
    instrOpcode <= op;
    @(posedge mclk);
    instrDone <= 1'b0;
  endtask
  task automatic waitRs(input int lim);
    while (n < lim) begin
      @(posedge mclk);
      #1;
      n++;
      if (restartPulse === 1'b1) break;
    end
    if (restartPulse !== 1'b1) err_count++;
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      err_count++;
      results();
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    u_wsr_pin_model.pinReset(30);
    n = 0;
    waitRs(40);
    `CHK(n inside {[10:15]}, 1'b1)
    `CHK(restartAddr, 16'h0020)
    rdc(wsr_pkg::OFS_TIMER_CONTROL_HIGH, 8'h70);
    rdc(wsr_pkg::OFS_COUNT_HIGH, 8'hFF);
    rdc(8'h80, 8'h00);
    wr(wsr_pkg::OFS_TIMER_CONTROL_HIGH, 8'h10);
    issue(8'h00);
    wr(wsr_pkg::OFS_TIMER_CONTROL_HIGH, 8'h00);
    rdc(wsr_pkg::OFS_TIMER_CONTROL_HIGH, 8'h10);
    $display("test control done");
    @(posedge mclk);
    dogRetrigger <= 1'b1;
    @(posedge mclk);
    dogRetrigger <= 1'b0;
    n = 4;
    rdc(wsr_pkg::OFS_COUNT_HIGH, expHigh(1));
    rdc(wsr_pkg::OFS_COUNT_LOW, 8'hFF);
    waitRs(70000);
    `CHK(n inside {[65536:65539]}, 1'b1)
    `CHK({dogFlag, restartAddr}, {1'b1, 16'h0020})
    rdc(wsr_pkg::OFS_FLAGS, 8'h02);
    rdc(wsr_pkg::OFS_FLAGS, 8'h02);
    wr(wsr_pkg::OFS_FLAGS, 8'h00);
    rdc(wsr_pkg::OFS_FLAGS, 8'h00);
    rdc(wsr_pkg::OFS_TIMER_CONTROL_HIGH, 8'h10);
    $display("test watchdog done");
    rnd = lfsr(rnd);
    wr(wsr_pkg::OFS_FLAGS, {rnd[7:2], 2'b00});
    issue(wsr_pkg::STOP_OPCODE);
    #1 `CHK({stopMode, oscEnable, recoveryFlag}, 3'b101)
    u_wsr_pin_model.wake(4);
    n = 0;
    waitRs(40);
    `CHK(restartAddr, 16'h0020)
    rdc(wsr_pkg::OFS_FLAGS, {rnd[7:2], 2'b01});
    rdc(wsr_pkg::OFS_TIMER_CONTROL_HIGH, 8'h10);
    $display("test stop done");
    rnd = lfsr(rnd);
    wr(wsr_pkg::OFS_FLAGS, {rnd[7:2], 2'b11});
    u_wsr_pin_model.pinReset(30);
    n = 0;
    waitRs(40);
    rdc(wsr_pkg::OFS_FLAGS, {rnd[7:2], 2'b00});
    rdc(wsr_pkg::OFS_TIMER_CONTROL_HIGH, 8'h70);
    $display("test pin reset done");
    wr(wsr_pkg::OFS_TIMER_CONTROL_HIGH, 8'h00);
    @(posedge mclk);
    dogRetrigger <= 1'b1;
    @(posedge mclk);
    dogRetrigger <= 1'b0;
    repeat (70) @(posedge mclk);
    rdc(wsr_pkg::OFS_COUNT_HIGH, 8'hFF);
    rdc(wsr_pkg::OFS_COUNT_LOW, 8'hFF);
    $display("test disable done");
    results();
  end
endmodule // wsr_watchdog_stop_recovery_tb_top
